//--- core/dac_mode_pkg.sv
// Constants shared by the audio DAC mode register bank
package dac_mode_pkg;

    // ********************************************
    // Control word layout
    // ********************************************
    localparam int unsigned WORD_BITS     = 16;
    localparam int unsigned RW_BIT        = 15;
    localparam int unsigned INDEX_MSB     = 14;
    localparam int unsigned INDEX_LSB     = 8;
    localparam logic [4:0]  CMD_DONE_CNT  = 5'h08;
    localparam logic [4:0]  WORD_DONE_CNT = 5'h10;
    localparam int unsigned SYNC_STAGES   = 3;

    // ********************************************
    // Register indices
    // ********************************************
    localparam logic [6:0] IDX_LEFT_LEVEL  = 7'h10;
    localparam logic [6:0] IDX_RIGHT_LEVEL = 7'h11;
    localparam logic [6:0] IDX_FORMAT_CTRL = 7'h12;
    localparam logic [6:0] IDX_FILTER_CLK  = 7'h13;
    localparam logic [6:0] IDX_RESET_SINGLE_CHANNEL_MODE  = 7'h14;
    localparam logic [6:0] IDX_ZERO_FLAGS  = 7'h15;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int unsigned B18_MUTE     = 0;
    localparam int unsigned B18_DEEMPH   = 1;
    localparam int unsigned B18_DMF_LSB  = 2;
    localparam int unsigned B18_FMT_LSB  = 4;
    localparam int unsigned B18_LOAD     = 7;
    localparam int unsigned B19_ZMUTE    = 0;
    localparam int unsigned B19_ROLLOFF  = 1;
    localparam int unsigned B19_CLKDIS   = 2;
    localparam int unsigned B19_CLKHALF  = 3;
    localparam int unsigned B19_DACOFF   = 4;
    localparam int unsigned B19_ATS_LSB  = 5;
    localparam int unsigned B19_PHASE    = 7;
    localparam int unsigned B20_OS_LSB   = 0;
    localparam int unsigned B20_CHSRC    = 2;
    localparam int unsigned B20_SINGLE_CHANNEL_MODE     = 3;
    localparam int unsigned B20_BYPASS   = 4;
    localparam int unsigned B20_SETTINGS_SOFT_RESET     = 5;
    localparam int unsigned B20_SYSTEM_SOFT_RESET     = 6;
    localparam int unsigned B20_ORDER    = 7;

    // ********************************************
    // Reset values and level decode
    // ********************************************
    localparam logic [7:0] RST_LEVEL     = 8'hff;
    localparam logic [7:0] RST_REG18     = 8'h00;
    localparam logic [7:0] RST_REG19     = 8'h00;
    localparam logic [7:0] RST_REG20     = 8'h00;
    localparam logic [7:0] LEVEL_MAX     = 8'hff;
    localparam logic [7:0] LEVEL_MUTE_LT = 8'h0f;

endpackage : dac_mode_pkg

//--- core/ctl_serial_port.sv
// Four-wire serial control port: pin synchronisers, word framing, readback shifter
`timescale 1ns/100ps
`default_nettype none
module ctl_serial_port
    import dac_mode_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ctl_sel_n,
    input  wire logic       i_ctl_clk,
    input  wire logic       i_ctl_din,
    input  wire logic [7:0] i_rd_data,
    output logic      [6:0] o_index,
    output logic            o_wr_stb,
    output logic      [7:0] o_wr_data,
    output logic            o_ctl_dout,
    output logic            o_ctl_dout_oe
);

    // ********************************************
    // Pin synchronisers
    // ********************************************
    logic [2:0] pin_raw;
    logic       pin_q [3];
    assign pin_raw = {i_ctl_sel_n, i_ctl_clk, i_ctl_din};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic [SYNC_STAGES-1:0] s_q;
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    s_q     <= '0;
                    pin_q[g] <= (g == 2) ? 1'b1 : 1'b0;
                end else begin
                    s_q <= {s_q[SYNC_STAGES-2:0], pin_raw[g]};
                    // Change accepted only once stages two and three agree
                    if (s_q[1] == s_q[2]) begin
                        pin_q[g] <= s_q[2];
                    end
                end
            end
        end
    endgenerate

    logic sel_n;
    logic sclk;
    logic din;
    logic sclk_prev_q;
    logic rise;
    logic fall;
    assign sel_n = pin_q[2];
    assign sclk  = pin_q[1];
    assign din   = pin_q[0];
    assign rise  = sclk & ~sclk_prev_q & ~sel_n;
    assign fall  = ~sclk & sclk_prev_q & ~sel_n;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk;
        end
    end

    // ********************************************
    // Word framing
    // ********************************************
    logic [4:0] cnt_q;
    logic [6:0] shift_q;
    logic [7:0] cmd_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q   <= '0;
            shift_q <= '0;
            cmd_q   <= '0;
        end else if (sel_n) begin
            cnt_q <= '0;
        end else if (rise && cnt_q != WORD_DONE_CNT) begin
            cnt_q   <= cnt_q + 5'h01;
            shift_q <= {shift_q[5:0], din};
            if (cnt_q == CMD_DONE_CNT - 5'h01) begin
                cmd_q <= {shift_q, din};
            end
        end
    end

    assign o_index = cmd_q[INDEX_MSB-INDEX_LSB:0];

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wr_stb  <= 1'b0;
            o_wr_data <= '0;
        end else begin
            o_wr_stb <= rise && cnt_q == WORD_DONE_CNT - 5'h01
                        && !cmd_q[RW_BIT-INDEX_LSB];
            if (rise && cnt_q == WORD_DONE_CNT - 5'h01) begin
                o_wr_data <= {shift_q, din};
            end
        end
    end

    // ********************************************
    // Readback shifter
    // ********************************************
    logic [7:0] out_q;
    logic       out_en_q;

    // Data is shifted on the falling edge so it is settled for the host's rise
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q    <= '0;
            out_en_q <= 1'b0;
        end else if (sel_n) begin
            out_en_q <= 1'b0;
        end else if (fall && cmd_q[RW_BIT-INDEX_LSB]) begin
            if (cnt_q == CMD_DONE_CNT) begin
                out_q    <= i_rd_data;
                out_en_q <= 1'b1;
            end else if (cnt_q > CMD_DONE_CNT) begin
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    assign o_ctl_dout    = out_q[7];
    assign o_ctl_dout_oe = out_en_q;

    chk_dout_only_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(out_en_q) |-> cmd_q[RW_BIT-INDEX_LSB] && cnt_q == CMD_DONE_CNT)
        else $error("readback driven outside a read data phase");

endmodule : ctl_serial_port
`default_nettype wire

//--- core/level_apply.sv
// Applied attenuation levels per channel with load gating and mute decode
`timescale 1ns/100ps
`default_nettype none
module level_apply
    import dac_mode_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_defaults,
    input  wire logic       i_load_enable,
    input  wire logic [1:0] i_level_stb,
    input  wire logic [7:0] i_level,
    output logic      [7:0] o_left_applied,
    output logic      [7:0] o_right_applied,
    output logic      [7:0] o_left_atten,
    output logic      [7:0] o_right_atten,
    output logic            o_left_mute,
    output logic            o_right_mute
);

    logic [7:0] applied [2];
    logic [7:0] atten   [2];
    logic       mute    [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    applied[g] <= RST_LEVEL;
                end else if (i_defaults) begin
                    applied[g] <= RST_LEVEL;
                // Old level stays in force while loading is off
                end else if (i_level_stb[g] && i_load_enable) begin
                    applied[g] <= i_level;
                end
            end
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    atten[g] <= '0;
                    mute[g]  <= 1'b0;
                end else begin
                    // Half-dB steps below full scale; low codes are mute
                    atten[g] <= LEVEL_MAX - applied[g];
                    mute[g]  <= applied[g] < LEVEL_MUTE_LT;
                end
            end
        end
    endgenerate

    assign o_left_applied  = applied[0];
    assign o_right_applied = applied[1];
    assign o_left_atten    = atten[0];
    assign o_right_atten   = atten[1];
    assign o_left_mute     = mute[0];
    assign o_right_mute    = mute[1];

endmodule : level_apply
`default_nettype wire

//--- core/audio_dac_mode_register_bank.sv
// Mode control register bank of a stereo audio DAC behind a serial control port
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Word bit 15 set means readback, clear means write.
// - Bits 14..8 carry the register index; 16 to 21 select mode registers.
// - All mode registers are reached only through the serial control port.
// - Register 16 holds the left level; reset gives no attenuation.
// - Register 17 holds the right level independently.
// - Levels span 0 to -120 dB in half-dB steps.
// - Register 19 bit 0 mutes both outputs on all-zero input; off at reset.
// - Register 18 format field picks input format; default 16-bit right-justified.
// - Register 18 de-emphasis enable and rate field; disabled at reset.
// - Register 19 roll-off bit picks sharp or slow; sharp by default.
// - Register 19 bit disables clock output pin; enabled after reset.
// - Register 19 bit halves clock output rate; full rate after reset.
// - Register 20 reset bit returns all mode registers to defaults.
// - Register 20 bit bypasses the internal filter; filter on by default.
// - Register 20 field picks modulator rate 64, 128 or 32; default 64.
// - Register 20 holds single_channel_mode select and single_channel_mode source; stereo and left default.
// - Read-only register 21 bit 0 left, bit 1 right zero flags.
// - Register 21 upper six bits are factory bits without user function.
// - Codes 15..255 attenuate by half dB per step below 255; 0..14 mute.
// - Level writes take effect only while the load bit is set.
// - Format codes 000..101 defined; 110 and 111 reserved.
module audio_dac_mode_register_bank
    import dac_mode_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ctl_sel_n,
    input  wire logic       i_ctl_clk,
    input  wire logic       i_ctl_din,
    output logic            o_ctl_dout,
    output logic            o_ctl_dout_oe,
    input  wire logic       i_left_zero_flag,
    input  wire logic       i_right_zero_flag,
    output logic      [7:0] o_left_level,
    output logic      [7:0] o_right_level,
    output logic      [7:0] o_left_atten,
    output logic      [7:0] o_right_atten,
    output logic            o_left_mute,
    output logic            o_right_mute,
    output logic            o_soft_mute,
    output logic      [1:0] o_fade_speed,
    output logic            o_zero_mute_active,
    output logic      [2:0] o_input_format_sel,
    output logic            o_format_reserved,
    output logic            o_deemph_enable,
    output logic      [1:0] o_deemph_rate_sel,
    output logic            o_rolloff_sel,
    output logic            o_phase_invert,
    output logic            o_dac_disable,
    output logic            o_clkout_disable,
    output logic            o_clkout_halve,
    output logic            o_system_soft_reset,
    output logic            o_filter_bypass,
    output logic      [1:0] o_modulator_rate_sel,
    output logic            o_modulator_order_sel,
    output logic            o_single_channel_mode,
    output logic            o_single_channel_source
);

    // ********************************************
    // Serial control port
    // ********************************************
    logic [6:0] index;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    ctl_serial_port u_port (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_ctl_sel_n   (i_ctl_sel_n),
        .i_ctl_clk     (i_ctl_clk),
        .i_ctl_din     (i_ctl_din),
        .i_rd_data     (rd_data),
        .o_index       (index),
        .o_wr_stb      (wr_stb),
        .o_wr_data     (wr_data),
        .o_ctl_dout    (o_ctl_dout),
        .o_ctl_dout_oe (o_ctl_dout_oe)
    );

    // ********************************************
    // Write decode
    // ********************************************
    logic wr_ok;
    logic defaults_load;

    // Register 21 and unknown indices fall outside this range
    assign wr_ok = wr_stb && index >= IDX_LEFT_LEVEL && index <= IDX_RESET_SINGLE_CHANNEL_MODE;
    assign defaults_load = wr_ok && index == IDX_RESET_SINGLE_CHANNEL_MODE && wr_data[B20_SETTINGS_SOFT_RESET];

    logic [7:0] left_q;
    logic [7:0] right_q;
    logic [7:0] reg18_q;
    logic [7:0] reg19_q;
    logic [7:0] reg20_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            left_q <= RST_LEVEL;
        end else if (defaults_load) begin
            left_q <= RST_LEVEL;
        end else if (wr_ok && index == IDX_LEFT_LEVEL) begin
            left_q <= wr_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            right_q <= RST_LEVEL;
        end else if (defaults_load) begin
            right_q <= RST_LEVEL;
        end else if (wr_ok && index == IDX_RIGHT_LEVEL) begin
            right_q <= wr_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            reg18_q <= RST_REG18;
        end else if (defaults_load) begin
            reg18_q <= RST_REG18;
        end else if (wr_ok && index == IDX_FORMAT_CTRL) begin
            reg18_q <= wr_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            reg19_q <= RST_REG19;
        end else if (defaults_load) begin
            reg19_q <= RST_REG19;
        end else if (wr_ok && index == IDX_FILTER_CLK) begin
            reg19_q <= wr_data;
        end
    end

    // Reset bit clears itself with the rest, so normal operation follows
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            reg20_q <= RST_REG20;
        end else if (defaults_load) begin
            reg20_q <= RST_REG20;
        end else if (wr_ok && index == IDX_RESET_SINGLE_CHANNEL_MODE) begin
            reg20_q <= wr_data;
        end
    end

    // ********************************************
    // Readback mux
    // ********************************************
    always_comb begin
        rd_data = '0;
        unique case (index)
            IDX_LEFT_LEVEL:  rd_data = left_q;
            IDX_RIGHT_LEVEL: rd_data = right_q;
            IDX_FORMAT_CTRL: rd_data = reg18_q;
            IDX_FILTER_CLK:  rd_data = reg19_q;
            IDX_RESET_SINGLE_CHANNEL_MODE:  rd_data = reg20_q;
            // Factory bits read as zero
            IDX_ZERO_FLAGS:  rd_data = {6'h00, i_right_zero_flag, i_left_zero_flag};
            default:         rd_data = '0;
        endcase
    end

    // ********************************************
    // Applied levels
    // ********************************************
    logic [1:0] level_stb;
    assign level_stb = {wr_ok && index == IDX_RIGHT_LEVEL, wr_ok && index == IDX_LEFT_LEVEL};

    level_apply u_level (
        .i_core_clk      (i_core_clk),
        .i_rst           (i_rst),
        .i_defaults      (defaults_load),
        .i_load_enable   (reg18_q[B18_LOAD]),
        .i_level_stb     (level_stb),
        .i_level         (wr_data),
        .o_left_applied  (o_left_level),
        .o_right_applied (o_right_level),
        .o_left_atten    (o_left_atten),
        .o_right_atten   (o_right_atten),
        .o_left_mute     (o_left_mute),
        .o_right_mute    (o_right_mute)
    );

    // ********************************************
    // Control outputs
    // ********************************************
    logic zero_mute_q;

    // Zero flags come from datapath logic on this clock, so no synchroniser
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            zero_mute_q <= 1'b0;
        end else begin
            zero_mute_q <= reg19_q[B19_ZMUTE] && i_left_zero_flag && i_right_zero_flag;
        end
    end

    assign o_zero_mute_active      = zero_mute_q;
    assign o_soft_mute             = reg18_q[B18_MUTE];
    assign o_deemph_enable         = reg18_q[B18_DEEMPH];
    assign o_deemph_rate_sel       = reg18_q[B18_DMF_LSB +: 2];
    assign o_input_format_sel      = reg18_q[B18_FMT_LSB +: 3];
    assign o_format_reserved       = reg18_q[B18_FMT_LSB + 2] && reg18_q[B18_FMT_LSB + 1];
    assign o_rolloff_sel           = reg19_q[B19_ROLLOFF];
    assign o_clkout_disable        = reg19_q[B19_CLKDIS];
    assign o_clkout_halve          = reg19_q[B19_CLKHALF];
    assign o_dac_disable           = reg19_q[B19_DACOFF];
    assign o_fade_speed            = reg19_q[B19_ATS_LSB +: 2];
    assign o_phase_invert          = reg19_q[B19_PHASE];
    assign o_modulator_rate_sel    = reg20_q[B20_OS_LSB +: 2];
    assign o_single_channel_source = reg20_q[B20_CHSRC];
    assign o_single_channel_mode   = reg20_q[B20_SINGLE_CHANNEL_MODE];
    assign o_filter_bypass         = reg20_q[B20_BYPASS];
    assign o_system_soft_reset     = reg20_q[B20_SYSTEM_SOFT_RESET];
    assign o_modulator_order_sel   = reg20_q[B20_ORDER];

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_left_write_lands: assert property (
        wr_stb && index == IDX_LEFT_LEVEL |=> left_q == $past(wr_data))
        else $error("left level write not stored");

    chk_right_independent: assert property (
        wr_stb && index == IDX_RIGHT_LEVEL |=> $stable(left_q) && right_q == $past(wr_data))
        else $error("right level write wrong or disturbed left");

    chk_ro_write_ignored: assert property (
        wr_stb && (index < IDX_LEFT_LEVEL || index > IDX_RESET_SINGLE_CHANNEL_MODE)
        |=> $stable(left_q) && $stable(right_q) && $stable(reg18_q)
            && $stable(reg19_q) && $stable(reg20_q))
        else $error("write to read-only or unknown index changed state");

    chk_soft_reset_defaults: assert property (
        defaults_load |=> left_q == RST_LEVEL && right_q == RST_LEVEL && reg18_q == RST_REG18
            && reg19_q == RST_REG19 && reg20_q == RST_REG20 ##2 o_left_level == RST_LEVEL)
        else $error("mode register reset did not restore defaults");

    chk_level_held_unloaded: assert property (
        level_stb[0] && !reg18_q[B18_LOAD] && !defaults_load |=> $stable(o_left_level))
        else $error("applied level changed while loading disabled");

    chk_level_loaded: assert property (
        level_stb[1] && reg18_q[B18_LOAD] |=> o_right_level == $past(wr_data))
        else $error("applied level not loaded while loading enabled");

    chk_mute_low_codes: assert property (
        o_left_level < LEVEL_MUTE_LT ##1 $stable(o_left_level) |-> o_left_mute)
        else $error("low level code did not mute");

    chk_zero_flag_read: assert property (
        index == IDX_ZERO_FLAGS |-> rd_data[7:2] == 6'h00
            && rd_data[1:0] == {i_right_zero_flag, i_left_zero_flag})
        else $error("zero flag readback wrong");

    chk_zero_mute_gate: assert property (
        !reg19_q[B19_ZMUTE] |=> !o_zero_mute_active)
        else $error("zero mute active while disabled");

endmodule : audio_dac_mode_register_bank
`default_nettype wire

//--- verification/ctl_host_model.sv
// Host controller model driving the four-wire serial control port
`timescale 1ns/100ps
`default_nettype none
module ctl_host_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_ctl_dout,
    input  wire logic       i_ctl_dout_oe,
    output var  logic       o_ctl_sel_n,
    output var  logic       o_ctl_clk,
    output var  logic       o_ctl_din,
    output var  logic       o_rd_done,
    output var  logic [7:0] o_rd_data
);
    // ****************************************
    // Pin levels and word transfer
    // ****************************************
    initial begin
        o_ctl_sel_n = 1'b1;
        o_ctl_clk   = 1'b1;
        o_ctl_din   = 1'b0;
        o_rd_done   = 1'b0;
        o_rd_data   = 8'h00;
    end

    task automatic hold(input int k);
        repeat (k) @(posedge i_core_clk);
    endtask : hold

    // Short words (n < 16) model an abandoned transfer
    task automatic word(input logic [15:0] w, input int n);
        logic [7:0] rd;
        rd = 8'h00;
        o_ctl_sel_n <= 1'b0;
        hold(5);
        for (int i = 0; i < n; i++) begin
            o_ctl_clk <= 1'b0;
            o_ctl_din <= w[15-i];
            // Low phase of 6 cycles: 4 to synchronise, 1 to shift, 1 to settle
            hold(6);
            if (i >= 8) rd[15-i] = i_ctl_dout & i_ctl_dout_oe;
            o_ctl_clk <= 1'b1;
            hold(5);
        end
        o_ctl_sel_n <= 1'b1;
        o_ctl_din   <= ~o_ctl_din;
        hold(6);
        if (w[15] && n == 16) begin
            o_rd_data <= rd;
            o_rd_done <= 1'b1;
            hold(1);
            o_rd_done <= 1'b0;
        end
    endtask : word
endmodule : ctl_host_model
`default_nettype wire

//--- verification/tb_audio_dac_mode_register_bank.sv
// Self-checking bench for the audio DAC mode register bank
`timescale 1ns/100ps
`default_nettype none
module tb_audio_dac_mode_register_bank;
    import dac_mode_pkg::*;
    logic i_core_clk = 0, i_rst = 1, i_left_zero_flag = 0, i_right_zero_flag = 0;
    logic sel_n, cclk, din, dout, oe, rd_done, sm, zm, fr, de, ro, ph, dd, cd, ch, sr, fb, mo, sc, sx;
    logic lm, rm;
    logic [1:0] fs, dr, os;
    logic [2:0] fmt;
    logic [7:0] rd_data, ll, rl, la, ra;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    int errors = 0, comparisons = 0, seed = 32'h4524;

    initial forever #25 i_core_clk = ~i_core_clk;

    ctl_host_model ctl_host_model_inst (.i_core_clk(i_core_clk), .i_ctl_dout(dout),
        .i_ctl_dout_oe(oe), .o_ctl_sel_n(sel_n), .o_ctl_clk(cclk), .o_ctl_din(din),
        .o_rd_done(rd_done), .o_rd_data(rd_data));

    audio_dac_mode_register_bank audio_dac_mode_register_bank_inst (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_ctl_sel_n(sel_n), .i_ctl_clk(cclk), .i_ctl_din(din), .o_ctl_dout(dout),
        .o_ctl_dout_oe(oe), .i_left_zero_flag(i_left_zero_flag),
        .i_right_zero_flag(i_right_zero_flag), .o_left_level(ll), .o_right_level(rl),
        .o_left_atten(la), .o_right_atten(ra), .o_left_mute(lm), .o_right_mute(rm),
        .o_soft_mute(sm), .o_fade_speed(fs), .o_zero_mute_active(zm), .o_input_format_sel(fmt),
        .o_format_reserved(fr), .o_deemph_enable(de), .o_deemph_rate_sel(dr),
        .o_rolloff_sel(ro), .o_phase_invert(ph), .o_dac_disable(dd), .o_clkout_disable(cd),
        .o_clkout_halve(ch), .o_system_soft_reset(sr), .o_filter_bypass(fb),
        .o_modulator_rate_sel(os), .o_modulator_order_sel(mo), .o_single_channel_mode(sc),
        .o_single_channel_source(sx));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] idx, input logic [7:0] v);
        ctl_host_model_inst.word({1'b0, idx, v}, 16);
    endtask : wr

    task automatic rd(input logic [6:0] idx, input logic [7:0] v, input logic [7:0] m);
        exp_q.push_back({m, v});
        ctl_host_model_inst.word({1'b1, idx, 8'h00}, 16);
    endtask : rd

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Read results are matched oldest note first
    always @(posedge i_core_clk) begin
        if (rd_done === 1'b1) begin
            note = exp_q.pop_front();
            chk(rd_data & note[15:8], note[7:0]);
        end
    end

    initial begin
        repeat (100000) @(posedge i_core_clk);
        errors++;
        tally_and_finish();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] v;
        logic [31:0] r;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk(ll, 8'hff);
        chk({6'h0, cd, ch}, 8'h00);
        rd(IDX_LEFT_LEVEL, 8'hff, 8'hff);
        rd(IDX_RIGHT_LEVEL, 8'hff, 8'hff);
        rd(IDX_FORMAT_CTRL, 8'h00, 8'hff);
        rd(IDX_FILTER_CLK, 8'h00, 8'hff);
        rd(IDX_RESET_SINGLE_CHANNEL_MODE, 8'h00, 8'hff);
        wr(IDX_LEFT_LEVEL, 8'h80);
        rd(IDX_LEFT_LEVEL, 8'h80, 8'hff);
        chk(ll, 8'hff);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            v = {1'b1, k[2:0], r[3:0]};
            wr(IDX_FORMAT_CTRL, v);
            rd(IDX_FORMAT_CTRL, v, 8'hff);
            chk({fr, fmt, dr, de, sm}, {(k > 5), v[6:0]});
        end
        wr(IDX_LEFT_LEVEL, 8'h0e);
        wr(IDX_RIGHT_LEVEL, 8'h0f);
        chk(ll, 8'h0e);
        chk(la, 8'hf1);
        chk(ra, 8'hf0);
        chk(rl, 8'h0f);
        chk({6'h0, lm, rm}, 8'h02);
        r = $random(seed);
        v = r[7:0] | 8'h01;
        wr(IDX_FILTER_CLK, v);
        rd(IDX_FILTER_CLK, v, 8'hff);
        chk({ph, fs, dd, ch, cd, ro, 1'b1}, v);
        i_left_zero_flag  <= 1'b1;
        i_right_zero_flag <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        chk({7'h0, zm}, 8'h01);
        i_right_zero_flag <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk({7'h0, zm}, 8'h00);
        rd(IDX_ZERO_FLAGS, 8'h01, 8'h03);
        r = $random(seed);
        v = r[7:0] & 8'hdf;
        wr(IDX_RESET_SINGLE_CHANNEL_MODE, v);
        rd(IDX_RESET_SINGLE_CHANNEL_MODE, v, 8'hff);
        chk({mo, sr, 1'b0, fb, sc, sx, os}, v);
        wr(IDX_ZERO_FLAGS, 8'hff);
        wr(7'h16, 8'h00);
        wr(7'h00, 8'h00);
        ctl_host_model_inst.word({1'b0, IDX_RIGHT_LEVEL, 8'h55}, 10);
        rd(IDX_LEFT_LEVEL, 8'h0e, 8'hff);
        rd(IDX_RIGHT_LEVEL, 8'h0f, 8'hff);
        rd(7'h30, 8'h00, 8'hff);
        wr(IDX_RESET_SINGLE_CHANNEL_MODE, 8'h20);
        chk(ll, 8'hff);
        rd(IDX_FORMAT_CTRL, 8'h00, 8'hff);
        rd(IDX_RESET_SINGLE_CHANNEL_MODE, 8'h00, 8'hff);
        for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge i_core_clk);
        if (exp_q.size() > 0) errors++;
        tally_and_finish();
    end
endmodule : tb_audio_dac_mode_register_bank
`default_nettype wire
